// File: rtl/flash_status_config_pkg.sv
// constants, field layouts and types of the flash status and configuration registers
// ****************************************************************
// ****************************************************************
package flash_status_config_pkg;
   typedef struct packed {
      logic controller_ready_bit;
      logic erase_suspended_bit;
      logic erase_fail_bit;
      logic program_fail_bit;
      logic supply_invalid_bit;
      logic program_suspended_bit;
      logic locked_block_error_bit;
      logic bank_write_or_word_ready_bit;
   } program_erase_status_t;

   typedef struct packed {
      logic read_select_bit;
      logic reserved_14;
      logic [2:0] first_data_latency_field;
      logic wait_polarity;
      logic data_hold;
      logic wait_timing;
      logic burst_sequential;
      logic rising_edge;
      logic [1:0] reserved_5_4;
      logic no_wrap;
      logic [2:0] burst_length;
   } bus_read_configuration_t;

   localparam logic [15:0] CONFIG_RESET = 16'hbfcf;
   localparam logic [15:0] CONFIG_WRITABLE = 16'hbfcf;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [2:0] LAT_CODE_2 = 3'h2;
   localparam logic [2:0] LAT_CODE_3 = 3'h3;
   localparam logic [2:0] LAT_CODE_4 = 3'h4;
   localparam logic [2:0] LAT_CODE_5 = 3'h5;
   localparam logic [2:0] LAT_CYC_2 = 3'h2;
   localparam logic [2:0] LAT_CYC_3 = 3'h3;
   localparam logic [2:0] LAT_CYC_4 = 3'h4;
   localparam logic [2:0] LAT_CYC_5 = 3'h5;
   localparam logic [2:0] LAT_CYC_RESERVED = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PROGRAM,
      ST_ERASE,
      ST_PROGRAM_SUSP,
      ST_ERASE_SUSP
   } op_state_t;
endpackage

// File: rtl/flash_status_config_regs.sv
// status register, read-mode configuration and first-data latency timer
`timescale 1ns/1ps
module flash_status_config_regs #(
   parameter int NUM_BANKS = 8
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_op_start,
   input wire logic i_op_is_erase,
   input wire logic i_target_locked,
   input wire logic i_vpp_low,
   input wire logic i_op_done,
   input wire logic i_verify_fail,
   input wire logic i_suspend_req,
   input wire logic i_resume_req,
   input wire logic [NUM_BANKS-1:0] i_bank_busy,
   input wire logic [$clog2(NUM_BANKS)-1:0] i_addr_bank,
   input wire logic i_efp_active,
   input wire logic i_efp_word_busy,
   input wire logic i_clear_status,
   input wire logic i_config_write,
   input wire logic [15:0] i_config_data,
   input wire logic i_addr_latch,
   output flash_status_config_pkg::program_erase_status_t o_status,
   output flash_status_config_pkg::bus_read_configuration_t o_config,
   output logic o_async_read,
   output logic o_op_run,
   output logic o_op_abort,
   output logic o_first_data
);
   import flash_status_config_pkg::*;

   // bank index must reach every bank and nothing beyond, so powers of two only
   if (NUM_BANKS < 2 || (NUM_BANKS & (NUM_BANKS - 1)) != 0) begin
      $error("NUM_BANKS must be a power of two of at least 2");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic vpp_meta;
      logic vpp_low;
      op_state_t op;
      program_erase_status_t status;
      bus_read_configuration_t cfg;
      logic [2:0] lat_cnt;
      logic lat_active;
      logic first_data;
      logic abort;
   } regs_t;

   regs_t r;
   regs_t next_r;

   function automatic logic [2:0] lat_cycles(input logic [2:0] code);
      unique case (code)
         LAT_CODE_2: lat_cycles = LAT_CYC_2;
         LAT_CODE_3: lat_cycles = LAT_CYC_3;
         LAT_CODE_4: lat_cycles = LAT_CYC_4;
         LAT_CODE_5: lat_cycles = LAT_CYC_5;
         // reserved codes run slowest so data is never early
         default: lat_cycles = LAT_CYC_RESERVED;
      endcase
   endfunction

   logic any_busy;
   logic addr_busy;
   assign any_busy = |i_bank_busy;
   assign addr_busy = i_bank_busy[i_addr_bank];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_r = r;
      next_r.vpp_meta = i_vpp_low;
      next_r.vpp_low = r.vpp_meta;
      next_r.abort = 1'b0;
      next_r.first_data = 1'b0;

      // clear first, so a same-cycle error event still lands
      if (i_clear_status) begin
         next_r.status.erase_fail_bit = 1'b0;
         next_r.status.program_fail_bit = 1'b0;
         next_r.status.supply_invalid_bit = 1'b0;
         next_r.status.locked_block_error_bit = 1'b0;
      end

      unique case (r.op)
         ST_IDLE: begin
            if (i_op_start) begin
               if (i_target_locked) begin
                  next_r.status.locked_block_error_bit = 1'b1;
                  next_r.abort = 1'b1;
               end else if (r.vpp_low) begin
                  next_r.status.supply_invalid_bit = 1'b1;
                  next_r.abort = 1'b1;
               end else begin
                  next_r.op = i_op_is_erase ? ST_ERASE : ST_PROGRAM;
               end
            end
         end
         ST_PROGRAM, ST_ERASE: begin
            if (i_op_done) begin
               next_r.op = ST_IDLE;
               if (i_verify_fail && r.op == ST_ERASE) begin
                  next_r.status.erase_fail_bit = 1'b1;
               end
               if (i_verify_fail && r.op == ST_PROGRAM) begin
                  next_r.status.program_fail_bit = 1'b1;
               end
            end else if (i_suspend_req) begin
               next_r.op = (r.op == ST_ERASE) ? ST_ERASE_SUSP : ST_PROGRAM_SUSP;
            end
         end
         ST_PROGRAM_SUSP: begin
            if (i_resume_req) begin
               next_r.op = ST_PROGRAM;
            end
         end
         ST_ERASE_SUSP: begin
            if (i_resume_req) begin
               next_r.op = ST_ERASE;
            end
         end
      endcase

      next_r.status.controller_ready_bit = ~any_busy;
      next_r.status.erase_suspended_bit = (next_r.op == ST_ERASE_SUSP);
      next_r.status.program_suspended_bit = (next_r.op == ST_PROGRAM_SUSP);
      if (!any_busy) begin
         next_r.status.bank_write_or_word_ready_bit = 1'b0;
      end else if (i_efp_active) begin
         next_r.status.bank_write_or_word_ready_bit = i_efp_word_busy;
      end else begin
         // only the bank selected by i_addr_bank is reported, not every busy bank
         next_r.status.bank_write_or_word_ready_bit = ~addr_busy;
      end

      // only the command path reaches the configuration
      if (i_config_write) begin
         next_r.cfg = bus_read_configuration_t'(i_config_data & CONFIG_WRITABLE);
      end

      if (r.lat_active) begin
         next_r.lat_cnt = r.lat_cnt - 3'h1;
         if (r.lat_cnt == 3'h1) begin
            next_r.lat_active = 1'b0;
            next_r.first_data = 1'b1;
         end
      end else if (i_addr_latch && !r.cfg.read_select_bit) begin
         next_r.lat_cnt = lat_cycles(r.cfg.first_data_latency_field);
         next_r.lat_active = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         r.vpp_meta <= 1'b0;
         r.vpp_low <= 1'b0;
         r.op <= ST_IDLE;
         r.status <= program_erase_status_t'(STATUS_RESET);
         r.cfg <= bus_read_configuration_t'(CONFIG_RESET);
         r.lat_cnt <= 3'h0;
         r.lat_active <= 1'b0;
         r.first_data <= 1'b0;
         r.abort <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign o_status = r.status;
   assign o_config = r.cfg;
   assign o_async_read = r.cfg.read_select_bit;
   assign o_op_run = (r.op == ST_PROGRAM) || (r.op == ST_ERASE);
   assign o_op_abort = r.abort;
   assign o_first_data = r.first_data;

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_ready_tracks_busy;
      @(posedge i_mclk) disable iff (!i_resetn)
         1'b1 |=> (o_status.controller_ready_bit == ~$past(any_busy));
   endproperty
   a_ready_tracks_busy: assert property (p_ready_tracks_busy) else $error("ready bit wrong");

   property p_erase_susp;
      @(posedge i_mclk) disable iff (!i_resetn)
         (r.op == ST_ERASE && i_suspend_req && !i_op_done) |=>
            o_status.erase_suspended_bit && !o_op_run;
   endproperty
   a_erase_susp: assert property (p_erase_susp) else $error("erase suspend not shown");

   property p_prog_resume;
      @(posedge i_mclk) disable iff (!i_resetn)
         (r.op == ST_PROGRAM_SUSP && i_resume_req) |=> !o_status.program_suspended_bit && o_op_run;
   endproperty
   a_prog_resume: assert property (p_prog_resume) else $error("program resume not shown");

   property p_locked_abort;
      @(posedge i_mclk) disable iff (!i_resetn)
         (r.op == ST_IDLE && i_op_start && i_target_locked) |=>
            o_status.locked_block_error_bit && o_op_abort && !o_op_run;
   endproperty
   a_locked_abort: assert property (p_locked_abort) else $error("locked block not aborted");

   property p_vpp_refuse;
      @(posedge i_mclk) disable iff (!i_resetn)
         (r.op == ST_IDLE && i_op_start && !i_target_locked && r.vpp_low) |=>
            o_status.supply_invalid_bit && o_op_abort;
   endproperty
   a_vpp_refuse: assert property (p_vpp_refuse) else $error("low supply not refused");

   property p_sticky;
      @(posedge i_mclk) disable iff (!i_resetn)
         (o_status.program_fail_bit && !i_clear_status) |=> o_status.program_fail_bit;
   endproperty
   a_sticky: assert property (p_sticky) else $error("error bit dropped");

   property p_erase_fail;
      @(posedge i_mclk) disable iff (!i_resetn)
         (r.op == ST_ERASE && i_op_done && i_verify_fail) |=> o_status.erase_fail_bit;
   endproperty
   a_erase_fail: assert property (p_erase_fail) else $error("erase failure lost");

   property p_idle_bit0;
      @(posedge i_mclk) disable iff (!i_resetn)
         o_status.controller_ready_bit |-> !o_status.bank_write_or_word_ready_bit;
   endproperty
   a_idle_bit0: assert property (p_idle_bit0) else $error("forbidden bit zero");

   property p_bank_bit0;
      @(posedge i_mclk) disable iff (!i_resetn)
         (any_busy && !i_efp_active) |=>
            (o_status.bank_write_or_word_ready_bit == ~$past(addr_busy));
   endproperty
   a_bank_bit0: assert property (p_bank_bit0) else $error("bank bit zero wrong");

   property p_efp_bit0;
      @(posedge i_mclk) disable iff (!i_resetn)
         (any_busy && i_efp_active) |=>
            (o_status.bank_write_or_word_ready_bit == $past(i_efp_word_busy));
   endproperty
   a_efp_bit0: assert property (p_efp_bit0) else $error("word ready bit wrong");

   property p_config_hold;
      @(posedge i_mclk) disable iff (!i_resetn)
         !i_config_write |=> $stable(o_config);
   endproperty
   a_config_hold: assert property (p_config_hold) else $error("config changed without command");

   property p_lat3;
      @(posedge i_mclk) disable iff (!i_resetn)
         (i_addr_latch && !r.lat_active && !o_async_read &&
          o_config.first_data_latency_field == LAT_CODE_3) |=>
            !o_first_data [*3] ##1 o_first_data;
   endproperty
   a_lat3: assert property (p_lat3) else $error("latency three wrong");

   property p_async_no_data;
      @(posedge i_mclk) disable iff (!i_resetn)
         (o_async_read && !r.lat_active) |=> !o_first_data;
   endproperty
   a_async_no_data: assert property (p_async_no_data) else $error("sync timer ran in async");

   c_prog_ok: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      r.op == ST_PROGRAM ##[1:50] r.op == ST_IDLE);
   c_erase_susp: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      o_status.erase_suspended_bit ##[1:50] !o_status.erase_suspended_bit);
   c_sync_read: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      !o_async_read && i_addr_latch ##[1:8] o_first_data);
   c_abort: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_op_abort);
endmodule

// File: dv/flash_host_model.sv
// host-side command issuer facing the status and configuration block
`timescale 1ns/1ps
module flash_host_model (
   input wire logic i_mclk,
   input wire logic i_word_ready_n,
   output logic [6:0] o_cmd,
   output logic [15:0] o_data
);
   // ****************************************************************
   // command pulses: start, done, suspend, resume, clear, config, latch
   // ****************************************************************
   initial begin
      o_cmd = 7'h0;
      o_data = 16'h0;
   end
   task automatic issue(input int k, input logic [15:0] d);
      @(negedge i_mclk);
      o_cmd[k] = 1'b1;
      o_data = d;
      @(negedge i_mclk);
      o_cmd[k] = 1'b0;
      // released bus shows the inverse, never a stale copy
      o_data = ~d;
   endtask
   // bounded, so a stuck word-busy flag cannot hang the host
   task automatic wait_word;
      repeat (20) if (i_word_ready_n === 1'b1) @(negedge i_mclk);
   endtask
endmodule

// File: dv/flash_status_config_regs_tb.sv
// self-checking bench for the flash status and configuration registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin mismatches++; \
$display("Error %s expected %h seen %h", n, e, g); end end
module flash_status_config_regs_tb;
   import flash_status_config_pkg::*;
   typedef struct {string n; logic [27:0] e; logic [27:0] m;} note_t;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic erase = 0, locked = 0, vpp = 0, vfail = 0, enhanced_factory_programming = 0, wbusy = 0;
   logic [3:0] busy = 4'h0;
   logic [1:0] abank = 2'h0;
   logic [6:0] cmd;
   logic [15:0] data;
   program_erase_status_t o_status;
   bus_read_configuration_t o_config;
   logic o_async_read, o_op_run, o_op_abort, o_first_data;
   wire logic [27:0] obs = {o_first_data, o_op_abort, o_op_run, o_async_read,
      o_config, o_status};
   int mismatches = 0, n_tests = 0, seed = 32'h56b8;
   note_t q[$];
   note_t nt;
   event ev;
   logic [15:0] d;
   logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   always #25 i_mclk = ~i_mclk;
   flash_host_model u_host (.i_mclk(i_mclk), .i_word_ready_n(o_status[0]),
      .o_cmd(cmd), .o_data(data));
   flash_status_config_regs #(.NUM_BANKS(4)) u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
      .i_op_start(cmd[0]), .i_op_is_erase(erase), .i_target_locked(locked),
      .i_vpp_low(vpp), .i_op_done(cmd[1]), .i_verify_fail(vfail),
      .i_suspend_req(cmd[2]), .i_resume_req(cmd[3]), .i_bank_busy(busy),
      .i_addr_bank(abank), .i_efp_active(enhanced_factory_programming), .i_efp_word_busy(wbusy),
      .i_clear_status(cmd[4]), .i_config_write(cmd[5]), .i_config_data(data),
      .i_addr_latch(cmd[6]), .o_status(o_status), .o_config(o_config),
      .o_async_read(o_async_read), .o_op_run(o_op_run), .o_op_abort(o_op_abort),
      .o_first_data(o_first_data));
   // ****************************************************************
   // notes, comparison and verdict
   // ****************************************************************
   task automatic note(input string n, input logic [27:0] m, input logic [27:0] e);
      q.push_back('{n, e & m, m});
      -> ev;
      #1;
   endtask
   task automatic st(input logic [7:0] e);
      note("status", 28'hff, {20'h0, e});
   endtask
   task automatic fl(input string n, input int b, input logic v);
      note(n, 28'h1 << b, {27'h0, v} << b);
   endtask
   task automatic tick;
      @(negedge i_mclk);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever begin
      @(ev);
      nt = q.pop_front();
      `CHK(nt.n, nt.e, obs & nt.m)
   end
   initial begin
      #250000;
      mismatches++;
      final_report;
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      repeat (10) @(posedge i_mclk);
      tick;
      i_resetn = 1'b1;
      st(8'h80);
      note("config", 28'hffff00, {4'h0, 16'hbfcf, 8'h0});
      fl("async", 24, 1'b1);
      u_host.issue(0, 16'h0);
      fl("run", 25, 1'b1);
      busy = 4'h2;
      abank = 2'h1;
      tick;
      st(8'h00);
      abank = 2'h2;
      tick;
      st(8'h01);
      u_host.issue(2, 16'h0);
      st(8'h05);
      fl("run", 25, 1'b0);
      u_host.issue(3, 16'h0);
      st(8'h01);
      vfail = 1;
      u_host.issue(1, 16'h0);
      st(8'h11);
      fl("run", 25, 1'b0);
      busy = 4'h0;
      vfail = 0;
      tick;
      st(8'h90);
      u_host.issue(4, 16'h0);
      st(8'h80);
      erase = 1;
      u_host.issue(0, 16'h0);
      u_host.issue(2, 16'h0);
      st(8'hc0);
      u_host.issue(3, 16'h0);
      st(8'h80);
      vfail = 1;
      u_host.issue(1, 16'h0);
      vfail = 0;
      repeat (5) tick;
      st(8'ha0);
      u_host.issue(4, 16'h0);
      erase = 0;
      locked = 1;
      u_host.issue(0, 16'h0);
      fl("abort", 26, 1'b1);
      st(8'h82);
      fl("run", 25, 1'b0);
      locked = 0;
      vpp = 1;
      repeat (3) tick;
      u_host.issue(0, 16'h0);
      st(8'h8a);
      fl("abort", 26, 1'b1);
      tick;
      fl("abort", 26, 1'b0);
      vpp = 0;
      u_host.issue(4, 16'h0);
      enhanced_factory_programming = 1;
      u_host.issue(0, 16'h0);
      busy = 4'h1;
      abank = 2'h0;
      wbusy = 1;
      tick;
      st(8'h01);
      wbusy = 0;
      u_host.wait_word;
      st(8'h00);
      busy = 4'h0;
      u_host.issue(1, 16'h0);
      st(8'h80);
      enhanced_factory_programming = 0;
      repeat (4) begin
         d = $random(seed);
         d[13:11] = codes[seed & 3];
         u_host.issue(5, d);
         note("config", 28'hffff00, {4'h0, d & 16'hbfcf, 8'h0});
         fl("async", 24, d[15]);
      end
      foreach (codes[i]) begin
         u_host.issue(5, {2'b00, codes[i], 11'h7cf});
         u_host.issue(6, 16'h0);
         repeat (codes[i] - 1) tick;
         fl("first_data", 27, 1'b0);
         tick;
         fl("first_data", 27, 1'b1);
         tick;
         fl("first_data", 27, 1'b0);
      end
      u_host.issue(5, 16'hbfcf);
      u_host.issue(6, 16'h0);
      repeat (8) begin
         tick;
         fl("first_data", 27, 1'b0);
      end
      final_report;
   end
endmodule
